// File: rtl/ambient_cal_defines.svh
// Register offsets, field positions and reset values of the ambient calibration block.
// Assumes inclusion by bare name from the design files.
`ifndef AMBIENT_CAL_DEFINES_SVH
`define AMBIENT_CAL_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define REG_SETUP       8'h00
`define REG_CTRL_A      8'h01
`define REG_CTRL_B      8'h02
`define REG_CTRL_C      8'h03
`define REG_STATUS      8'h08
`define STAGE_REGION    2'h2
`define SF_POS_OFF      3'h0
`define SF_NEG_OFF      3'h1
`define SF_AMBIENT      3'h2
`define SF_UPPER        3'h3
`define SF_LOWER        3'h4

// ****************************************************************
// Field positions
// ****************************************************************
`define SETUP_STAGES    2:0
`define SETUP_DECIM     4:3
`define SETUP_LOW_POWER 5
`define SETUP_POS_SENS  11:8
`define SETUP_NEG_SENS  15:12
`define CA_FP_SKIP      13:12
`define CA_LP_SKIP      15:14
`define CB_FF_SKIP      3:0
`define CC_CHANGE_LVL   15:14
`define ADDR_REGION     7:6
`define ADDR_STAGE      5:3
`define ADDR_FIELD      2:0

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define SETUP_RST       16'h0007
`define CTRL_RST        16'h0000
`define WORD_ZERO       16'h0000
`define FP_SKIP_ZERO    2'h3
`define SENS_SHIFT      4

`endif

// File: rtl/ambient_cal_pkg.sv
// Types shared by the ambient calibration block.
// Assumes the defines header is not needed here.
package ambient_cal_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [2:0]  stage;
    logic [15:0] data;
  } conv_sample_s;

endpackage

// File: rtl/trip_level_calc.sv
// Trip level computation from ambient, offsets and sensitivity.
// Assumes purely combinational use inside the calibration block.
`timescale 1ns/1ps
`default_nettype none
`include "ambient_cal_defines.svh"

module trip_level_calc #(
  parameter int DATA_W = 16
) (
  input  wire logic [DATA_W-1:0] ambient,
  input  wire logic [DATA_W-1:0] pos_off,
  input  wire logic [DATA_W-1:0] neg_off,
  input  wire logic [3:0]        pos_sens,
  input  wire logic [3:0]        neg_sens,
  output logic      [DATA_W-1:0] upper,
  output logic      [DATA_W-1:0] lower
);

  logic [DATA_W+4:0] pos_prod;
  logic [DATA_W+4:0] neg_prod;

  // Sensitivity n selects (n+1)/16 of the offset above or below ambient
  always_comb begin
    pos_prod = pos_off * {1'b0, pos_sens} + pos_off;
    neg_prod = neg_off * {1'b0, neg_sens} + neg_off;
    upper    = ambient + pos_prod[DATA_W+`SENS_SHIFT-1:`SENS_SHIFT];
    lower    = ambient - neg_prod[DATA_W+`SENS_SHIFT-1:`SENS_SHIFT];
  end

endmodule
`default_nettype wire

// File: rtl/ambient_calibration_fifo_control.sv
// Ambient calibration: skip counters, slow FIFOs, offset and trip level tracking.
// Assumes a conversion sequencer delivering one sample per stage in stage order.
`timescale 1ns/1ps
`default_nettype none
`include "ambient_cal_defines.svh"

module ambient_calibration_fifo_control #(
  parameter int STAGES     = 8,
  parameter int DATA_W     = 16,
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic                          clk,
  input  wire logic                          ce,
  input  wire logic                          sys_rst,
  input  wire ambient_cal_pkg::reg_req_s     reg_req,
  output logic      [15:0]                   reg_rdata,
  input  wire logic                          conv_valid,
  input  wire ambient_cal_pkg::conv_sample_s conv,
  input  wire logic [STAGES-1:0]             proximity,
  output logic      [STAGES-1:0]             stage_over,
  output logic                               host_alert
);

  localparam int LG = $clog2(FIFO_DEPTH);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [15:0]       setup;
  logic [15:0]       ctrl_a;
  logic [15:0]       ctrl_b;
  logic [15:0]       ctrl_c;
  logic [3:0]        fast_cnt;
  logic [1:0]        slow_cnt;
  logic              restart;
  logic [15:0]       next_setup;
  logic [15:0]       next_ctrl_a;
  logic [15:0]       next_ctrl_b;
  logic [15:0]       next_ctrl_c;
  logic [3:0]        next_fast_cnt;
  logic [1:0]        next_slow_cnt;
  logic              next_restart;
  logic [15:0]       next_rdata;
  logic [STAGES-1:0] next_over;
  logic              next_alert;

  logic [DATA_W-1:0] pos_off     [STAGES];
  logic [DATA_W-1:0] neg_off     [STAGES];
  logic [DATA_W-1:0] ambient     [STAGES];
  logic [DATA_W-1:0] upper       [STAGES];
  logic [DATA_W-1:0] lower       [STAGES];
  logic [DATA_W-1:0] last_push   [STAGES];
  logic [DATA_W-1:0] slow_fifo   [STAGES][FIFO_DEPTH];
  logic [STAGES-1:0] primed;
  logic [DATA_W-1:0] next_pos_off   [STAGES];
  logic [DATA_W-1:0] next_neg_off   [STAGES];
  logic [DATA_W-1:0] next_ambient   [STAGES];
  logic [DATA_W-1:0] next_upper     [STAGES];
  logic [DATA_W-1:0] next_lower     [STAGES];
  logic [DATA_W-1:0] next_last_push [STAGES];
  logic [DATA_W-1:0] next_slow_fifo [STAGES][FIFO_DEPTH];
  logic [STAGES-1:0] next_primed;

  // ****************************************************************
  // Sequence timing and slow FIFO candidate values
  // ****************************************************************
  logic [2:0]        s;
  logic              seq_end;
  logic              fast_take;
  logic [1:0]        slow_skip;
  logic              slow_take;
  logic [DATA_W:0]   diff;
  logic              push;
  logic [DATA_W-1:0] row [FIFO_DEPTH];
  logic [DATA_W+LG-1:0] sum;
  logic [DATA_W-1:0] new_amb;
  logic [DATA_W-1:0] drift;
  logic [DATA_W-1:0] upd_amb;
  logic [DATA_W-1:0] upd_pos;
  logic [DATA_W-1:0] upd_neg;
  logic [DATA_W-1:0] trip_hi;
  logic [DATA_W-1:0] trip_lo;

  function automatic logic stage_hit(input logic [7:0] a);
    stage_hit = (a[`ADDR_REGION] == `STAGE_REGION) && (32'(a[`ADDR_STAGE]) < STAGES);
  endfunction

  always_comb begin
    s         = conv.stage;
    seq_end   = conv_valid && (conv.stage == setup[`SETUP_STAGES]);
    fast_take = (fast_cnt == ctrl_b[`CB_FF_SKIP]);
    if (setup[`SETUP_LOW_POWER]) begin
      slow_skip = ctrl_a[`CA_LP_SKIP];
    end else if (ctrl_a[`CA_FP_SKIP] == 2'h0) begin
      slow_skip = `FP_SKIP_ZERO;
    end else begin
      slow_skip = ctrl_a[`CA_FP_SKIP] - 2'h1;
    end
    slow_take = fast_take && (slow_cnt == slow_skip);
    diff      = (conv.data >= last_push[s]) ? {1'b0, conv.data - last_push[s]}
                                            : {1'b0, last_push[s] - conv.data};
    // Untouched, not approached, and changed enough
    push = conv_valid && slow_take && !proximity[s] && !stage_over[s]
           && (diff > {{(DATA_W-1){1'b0}}, ctrl_c[`CC_CHANGE_LVL]});
    sum = '0;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      if (!primed[s]) begin
        row[i] = conv.data;
      end else if (i == 0) begin
        row[i] = conv.data;
      end else begin
        row[i] = slow_fifo[s][i-1];
      end
      sum = sum + {{LG{1'b0}}, row[i]};
    end
    new_amb = sum[DATA_W+LG-1:LG];
    drift   = new_amb - ambient[s];
    upd_amb = push ? new_amb : ambient[s];
    upd_pos = push ? pos_off[s] + drift : pos_off[s];
    upd_neg = push ? neg_off[s] + drift : neg_off[s];
  end

  trip_level_calc #(
    .DATA_W (DATA_W)
  ) u_trip (
    .ambient  (upd_amb),
    .pos_off  (upd_pos),
    .neg_off  (upd_neg),
    .pos_sens (setup[`SETUP_POS_SENS]),
    .neg_sens (setup[`SETUP_NEG_SENS]),
    .upper    (trip_hi),
    .lower    (trip_lo)
  );

  // ****************************************************************
  // Control registers, counters and status
  // ****************************************************************
  always_comb begin
    next_setup    = setup;
    next_ctrl_a   = ctrl_a;
    next_ctrl_b   = ctrl_b;
    next_ctrl_c   = ctrl_c;
    next_fast_cnt = fast_cnt;
    next_slow_cnt = slow_cnt;
    next_restart  = restart;
    next_over     = stage_over;
    next_rdata    = reg_rdata;
    if (conv_valid) begin
      next_over[s] = (conv.data > upper[s]) || (conv.data < lower[s]);
    end
    if (seq_end) begin
      if (restart) begin
        next_fast_cnt = 4'h0;
        next_slow_cnt = 2'h0;
        next_restart  = 1'b0;
      end else if (fast_take) begin
        next_fast_cnt = 4'h0;
        next_slow_cnt = slow_take ? 2'h0 : slow_cnt + 2'h1;
      end else begin
        next_fast_cnt = fast_cnt + 4'h1;
      end
    end
    // A setup or control A/B write in the same cycle as a sequence end still restarts next sequence
    if (reg_req.wr) begin
      if (reg_req.addr == `REG_SETUP) begin
        next_setup   = reg_req.wdata;
        next_restart = 1'b1;
      end else if (reg_req.addr == `REG_CTRL_A) begin
        next_ctrl_a  = reg_req.wdata;
        next_restart = 1'b1;
      end else if (reg_req.addr == `REG_CTRL_B) begin
        next_ctrl_b  = reg_req.wdata;
        next_restart = 1'b1;
      end else if (reg_req.addr == `REG_CTRL_C) begin
        next_ctrl_c  = reg_req.wdata;
      end
    end
    if (reg_req.rd) begin
      if (reg_req.addr == `REG_SETUP) begin
        next_rdata = setup;
      end else if (reg_req.addr == `REG_CTRL_A) begin
        next_rdata = ctrl_a;
      end else if (reg_req.addr == `REG_CTRL_B) begin
        next_rdata = ctrl_b;
      end else if (reg_req.addr == `REG_CTRL_C) begin
        next_rdata = ctrl_c;
      end else if (reg_req.addr == `REG_STATUS) begin
        next_rdata = 16'(stage_over);
      end else if (stage_hit(reg_req.addr)) begin
        case (reg_req.addr[`ADDR_FIELD])
          `SF_POS_OFF: next_rdata = 16'(pos_off[reg_req.addr[`ADDR_STAGE]]);
          `SF_NEG_OFF: next_rdata = 16'(neg_off[reg_req.addr[`ADDR_STAGE]]);
          `SF_AMBIENT: next_rdata = 16'(ambient[reg_req.addr[`ADDR_STAGE]]);
          `SF_UPPER:   next_rdata = 16'(upper[reg_req.addr[`ADDR_STAGE]]);
          `SF_LOWER:   next_rdata = 16'(lower[reg_req.addr[`ADDR_STAGE]]);
          default:     next_rdata = `WORD_ZERO;
        endcase
      end else begin
        next_rdata = `WORD_ZERO;
      end
    end
    next_alert = |next_over;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      setup      <= `SETUP_RST;
      ctrl_a     <= `CTRL_RST;
      ctrl_b     <= `CTRL_RST;
      ctrl_c     <= `CTRL_RST;
      fast_cnt   <= 4'h0;
      slow_cnt   <= 2'h0;
      restart    <= 1'b0;
      stage_over <= '0;
      host_alert <= 1'b0;
      reg_rdata  <= `WORD_ZERO;
    end else if (ce) begin
      setup      <= next_setup;
      ctrl_a     <= next_ctrl_a;
      ctrl_b     <= next_ctrl_b;
      ctrl_c     <= next_ctrl_c;
      fast_cnt   <= next_fast_cnt;
      slow_cnt   <= next_slow_cnt;
      restart    <= next_restart;
      stage_over <= next_over;
      host_alert <= next_alert;
      reg_rdata  <= next_rdata;
    end
  end

  // ****************************************************************
  // Per-stage calibration memory
  // ****************************************************************
  always_comb begin
    next_pos_off   = pos_off;
    next_neg_off   = neg_off;
    next_ambient   = ambient;
    next_upper     = upper;
    next_lower     = lower;
    next_last_push = last_push;
    next_slow_fifo = slow_fifo;
    next_primed    = primed;
    if (conv_valid) begin
      next_upper[s] = trip_hi;
      next_lower[s] = trip_lo;
    end
    if (push) begin
      next_slow_fifo[s] = row;
      next_primed[s]    = 1'b1;
      next_last_push[s] = conv.data;
      next_ambient[s]   = upd_amb;
      next_pos_off[s]   = upd_pos;
      next_neg_off[s]   = upd_neg;
    end
    // Software seeds initial offsets; its write takes priority
    if (reg_req.wr && stage_hit(reg_req.addr)) begin
      if (reg_req.addr[`ADDR_FIELD] == `SF_POS_OFF) begin
        next_pos_off[reg_req.addr[`ADDR_STAGE]] = DATA_W'(reg_req.wdata);
      end else if (reg_req.addr[`ADDR_FIELD] == `SF_NEG_OFF) begin
        next_neg_off[reg_req.addr[`ADDR_STAGE]] = DATA_W'(reg_req.wdata);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < STAGES; i++) begin
        pos_off[i]   <= '0;
        neg_off[i]   <= '0;
        ambient[i]   <= '0;
        upper[i]     <= '0;
        lower[i]     <= '0;
        last_push[i] <= '0;
        for (int j = 0; j < FIFO_DEPTH; j++) begin
          slow_fifo[i][j] <= '0;
        end
      end
      primed <= '0;
    end else if (ce) begin
      pos_off   <= next_pos_off;
      neg_off   <= next_neg_off;
      ambient   <= next_ambient;
      upper     <= next_upper;
      lower     <= next_lower;
      last_push <= next_last_push;
      slow_fifo <= next_slow_fifo;
      primed    <= next_primed;
    end
  end

endmodule
`default_nettype wire

// File: testbench/ambient_cal_asserts.sv
// Port checker for the ambient calibration block.
// Assumes one clock domain and binding to the top module.
`timescale 1ns/1ps
`default_nettype none

module ambient_cal_asserts #(
  parameter int STAGES     = 8,
  parameter int DATA_W     = 16,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic                          clk,
  input wire logic                          ce,
  input wire logic                          sys_rst,
  input wire ambient_cal_pkg::reg_req_s     reg_req,
  input wire logic [15:0]                   reg_rdata,
  input wire logic                          conv_valid,
  input wire ambient_cal_pkg::conv_sample_s conv,
  input wire logic [STAGES-1:0]             proximity,
  input wire logic [STAGES-1:0]             stage_over,
  input wire logic                          host_alert
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ****************
  // Register bus
  // ****************
  sequence wr_ctrl_seq;
    ce && reg_req.wr && reg_req.addr == 8'h01;
  endsequence

  sequence rd_ctrl_seq;
    ce && reg_req.rd && !reg_req.wr && reg_req.addr == 8'h01;
  endsequence

  ctrl_readback_a: assert property (
    wr_ctrl_seq ##1 rd_ctrl_seq |=> reg_rdata == $past(reg_req.wdata, 2))
    else $error("control A readback differs from written word");
  rdata_hold_a: assert property (
    !(ce && reg_req.rd) |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  unmapped_read_a: assert property (
    ce && reg_req.rd && reg_req.addr[7:6] == 2'h3 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  status_read_a: assert property (
    ce && reg_req.rd && reg_req.addr == 8'h08 |=> reg_rdata == 16'($past(stage_over)))
    else $error("status read differs from over flags");

  // ****************
  // Trip flags
  // ****************
  alert_or_a: assert property (
    host_alert == |stage_over)
    else $error("alert is not the OR of over flags");
  over_hold_a: assert property (
    !(ce && conv_valid) |=> $stable(stage_over))
    else $error("over flags changed without a sample");
  other_bits_a: assert property (
    ce && conv_valid |=>
      ((stage_over ^ $past(stage_over)) & ~(STAGES'(1) << $past(conv.stage))) == '0)
    else $error("sample changed the flag of another stage");
  rst_clear_a: assert property (disable iff (1'h0)
    sys_rst |=> stage_over == '0 && !host_alert && reg_rdata == 16'h0000)
    else $error("reset did not clear outputs");
endmodule

bind ambient_calibration_fifo_control ambient_cal_asserts #(
  .STAGES(STAGES), .DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH)
) ambient_cal_asserts_inst (
  .clk(clk), .ce(ce), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .conv_valid(conv_valid), .conv(conv), .proximity(proximity),
  .stage_over(stage_over), .host_alert(host_alert)
);
`default_nettype wire

// File: testbench/tb_ambient_calibration_fifo_control.sv
// Self-checking bench for the ambient calibration block.
// Assumes mostly one-stage sequences on stage 0 and the bound port checker.
`timescale 1ns/1ps
`default_nettype none

module tb_ambient_calibration_fifo_control;
  typedef struct packed {
    logic [15:0] data;
    logic        prox;
    logic        over;
    logic [15:0] amb;
  } row_s;

  // Sample, proximity, expected flag, expected ambient afterwards
  localparam row_s ROWS [22] = '{
    '{16'h1000, 1'h0, 1'h1, 16'h1000},
    '{16'h1008, 1'h0, 1'h0, 16'h1000},
    '{16'h1008, 1'h0, 1'h0, 16'h1002},
    '{16'h1200, 1'h1, 1'h1, 16'h1002},
    '{16'h0E00, 1'h0, 1'h1, 16'h1002},
    '{16'h1008, 1'h0, 1'h0, 16'h1002},
    '{16'h1110, 1'h0, 1'h0, 16'h1046},
    '{16'h115B, 1'h1, 1'h1, 16'h1046},
    '{16'h115A, 1'h0, 1'h0, 16'h1046},
    '{16'h1113, 1'h0, 1'h0, 16'h1046},
    '{16'h1114, 1'h0, 1'h0, 16'h108B},
    '{16'h1114, 1'h0, 1'h0, 16'h108B},
    '{16'h1100, 1'h0, 1'h0, 16'h108B},
    '{16'h1100, 1'h0, 1'h0, 16'h10CB},
    '{16'h1100, 1'h0, 1'h0, 16'h10CB},
    '{16'h1120, 1'h0, 1'h0, 16'h10CB},
    '{16'h1120, 1'h0, 1'h0, 16'h10CB},
    '{16'h1120, 1'h0, 1'h0, 16'h10CB},
    '{16'h1120, 1'h0, 1'h0, 16'h1111},
    '{16'h1120, 1'h0, 1'h0, 16'h1111},
    '{16'h1140, 1'h0, 1'h0, 16'h1111},
    '{16'h1140, 1'h0, 1'h0, 16'h111D}
  };

  // Address and expected read word
  localparam logic [23:0] REGS [13] = '{
    24'h000007, 24'h010000, 24'h020000, 24'h030000, 24'h080000, 24'h040000, 24'h820000,
    24'h82111D, 24'h80121D, 24'h81121D, 24'h83123E, 24'h840FFC, 24'hC00000
  };

  logic                          clk;
  logic                          ce;
  logic                          sys_rst;
  logic                          wr;
  logic                          rd;
  logic                          conv_valid;
  logic                          host_alert;
  logic [2:0]                    stage;
  logic [7:0]                    addr;
  logic [7:0]                    proximity;
  logic [7:0]                    stage_over;
  logic [15:0]                   wdata;
  logic [15:0]                   data;
  logic [15:0]                   reg_rdata;
  ambient_cal_pkg::reg_req_s     reg_req;
  ambient_cal_pkg::conv_sample_s conv;
  int                            errors = 0;
  int                            comparisons = 0;
  int                            cycles = 0;

  assign reg_req = '{wr, rd, addr, wdata};
  assign conv = '{stage, data};

  ambient_calibration_fifo_control ambient_calibration_fifo_control_inst (
    .clk(clk), .ce(ce), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .conv_valid(conv_valid), .conv(conv), .proximity(proximity),
    .stage_over(stage_over), .host_alert(host_alert)
  );

  // ****************
  // Tasks
  // ****************
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    wr = 1'h1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'h0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
    rd = 1'h1;
    addr = a;
    @(negedge clk);
    chk("reg_rdata", reg_rdata, exp);
    rd = 1'h0;
    @(negedge clk);
  endtask

  task automatic rd_table(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      rd_reg(REGS[i][23:16], REGS[i][15:0]);
    end
  endtask

  task automatic run_rows(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      conv_valid = 1'h1;
      data = ROWS[i].data;
      proximity = {7'h00, ROWS[i].prox};
      @(negedge clk);
      conv_valid = 1'h0;
      chk("stage_over", {8'h00, stage_over}, {15'h0000, ROWS[i].over});
      chk("host_alert", {15'h0000, host_alert}, {15'h0000, ROWS[i].over});
      rd_reg(8'h08, {15'h0000, ROWS[i].over});
      rd_reg(8'h82, ROWS[i].amb);
    end
  endtask

  // ****************
  // Clock, timeout and sequence
  // ****************
  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    clk = 1'h0;
    ce = 1'h1;
    sys_rst = 1'h1;
    wr = 1'h0;
    rd = 1'h0;
    addr = 8'h00;
    wdata = 16'h0000;
    conv_valid = 1'h0;
    data = 16'h0000;
    proximity = 8'h00;
    stage = 3'h0;
    repeat (3) @(negedge clk);
    sys_rst = 1'h0;
    rd_table(0, 6);
    wr_reg(8'h00, 16'h0000);
    wr_reg(8'h01, 16'h1000);
    rd_reg(8'h01, 16'h1000);
    wr_reg(8'h03, 16'hC000);
    wr_reg(8'h80, 16'h0100);
    wr_reg(8'h81, 16'h0100);
    run_rows(0, 10);
    wr_reg(8'h02, 16'h0001);
    run_rows(11, 13);
    wr_reg(8'h02, 16'h0000);
    wr_reg(8'h01, 16'h0000);
    run_rows(14, 18);
    wr_reg(8'h00, 16'h0020);
    wr_reg(8'h01, 16'h4000);
    run_rows(19, 21);
    ce = 1'h0;
    conv_valid = 1'h1;
    data = 16'h0000;
    rd = 1'h1;
    addr = 8'h80;
    @(negedge clk);
    ce = 1'h1;
    conv_valid = 1'h0;
    rd = 1'h0;
    chk("stage_over", {8'h00, stage_over}, 16'h0000);
    chk("reg_rdata", reg_rdata, 16'h111D);
    wr_reg(8'h82, 16'hFFFF);
    wr_reg(8'hC0, 16'h1234);
    rd_table(7, 12);
    // Two-stage sequences: only the last stage's sample ends a sequence
    wr_reg(8'h00, 16'h0021);
    for (int i = 0; i < 5; i++) begin
      stage = 3'(i % 2);
      conv_valid = 1'h1;
      data = (i % 2 == 0) ? 16'h1160 : 16'h1140;
      @(negedge clk);
      conv_valid = 1'h0;
      rd_reg(8'h82, (i == 4) ? 16'h1130 : 16'h111D);
    end
    stage = 3'h0;
    chk("stage_over", {8'h00, stage_over}, 16'h0002);
    chk("host_alert", {15'h0000, host_alert}, 16'h0001);
    sys_rst = 1'h1;
    @(negedge clk);
    sys_rst = 1'h0;
    rd_table(0, 6);
    test_done();
  end
endmodule
`default_nettype wire
